// ---- mda_defines.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef MDA_DEFINES_SVH
`define MDA_DEFINES_SVH
// register byte offsets
`define MDA_OFS_CFG    8'h00
`define MDA_OFS_ANL    8'h04
`define MDA_OFS_DO0    8'h08
`define MDA_OFS_DO1    8'h0c
`define MDA_OFS_LSEL1  8'h10
`define MDA_OFS_LSEL2  8'h14
`define MDA_OFS_STAT   8'h18
`define MDA_OFS_HIST   8'h1c
// configuration fields
`define MDA_CFG_INIT   4:0
`define MDA_CFG_SPD    10:8
`define MDA_CFG_FILT   19:16
`define MDA_CFG_PID    25:24
// terminal function fields, one per byte
`define MDA_FLD_STEP   8
`define MDA_ANL_W      5
`define MDA_DO_W       7
`define MDA_N_ANL      3
// status fields
`define MDA_ST_MODE    0
`define MDA_ST_LATCH   1
`define MDA_ST_SHOW    2
`define MDA_ST_IDX     11:8
`define MDA_ST_ITEM    20:16
`define MDA_ST_CODE    29:24
// history entry valid bit
`define MDA_HIST_VLD   7
// reset values
`define MDA_RST_CFG    32'h0000_0000
`define MDA_RST_FN     32'h0000_0000
`define MDA_RST_LSEL   32'h0000_0000
// function codes that enable a feature
`define MDA_FN_LIGHT_ALARM_OUTPUT    7'h62
`define MDA_FN_ANLMON  5'h14
// display limits
`define MDA_N_ITEMS    14
`define MDA_N_QTY      20
`define MDA_DISP_MAX   14'h270f
`define MDA_DIV        4'ha
`define MDA_FRAC       15
// timing: clock in MHz, filter sample period in us, blink half period in ms
`define MDA_CLK_MHZ    32'hc8
`define MDA_SAMPLE_US  32'h3e8
`define MDA_US_PER_MS  32'h3e8
`define MDA_BLINK_MS   32'hfa
`endif

// ---- mda_pkg.sv ----
// types shared by the monitor display block
package mda_pkg;
  typedef enum logic [0:0] {MDA_RUN = 1'b0, MDA_ALARM = 1'b1} mda_mode_e;
  typedef enum logic [4:0] {
    IT_SPEED = 5'h00, IT_CURR = 5'h03, IT_VOLT = 5'h04, IT_TORQ = 5'h08,
    IT_PWR   = 5'h09, IT_PIDC = 5'h0a, IT_PIDF = 5'h0c, IT_PIDO = 5'h0e,
    IT_LOAD  = 5'h0f, IT_MOUT = 5'h10, IT_ANLG = 5'h11, IT_TCUR = 5'h17,
    IT_FLUX  = 5'h18, IT_ENER = 5'h19
  } mda_item_e;
  typedef enum logic [2:0] {
    SP_F1 = 3'h0, SP_F2 = 3'h1, SP_REF = 3'h2, SP_MOT = 3'h3,
    SP_SHAFT = 3'h4, SP_LINE = 3'h5, SP_PCT = 3'h7
  } mda_spd_e;
  typedef enum logic [4:0] {
    Q_F1 = 5'h00, Q_F2 = 5'h01, Q_REF = 5'h02, Q_MOT = 5'h03,
    Q_SHAFT = 5'h04, Q_LINE = 5'h05, Q_SPCT = 5'h06, Q_CURR = 5'h07,
    Q_VOLT = 5'h08, Q_TORQ = 5'h09, Q_PWR = 5'h0a, Q_PIDC = 5'h0b,
    Q_PIDF = 5'h0c, Q_PIDO = 5'h0d, Q_LOAD = 5'h0e, Q_MOUT = 5'h0f,
    Q_ANLG = 5'h10, Q_TCUR = 5'h11, Q_FLUX = 5'h12, Q_ENER = 5'h13
  } mda_qty_e;
  typedef enum logic [1:0] {
    CH_NONE = 2'h0, CH_VOLT = 2'h1, CH_PCT = 2'h2
  } mda_char_e;
endpackage

// ---- mda_monitor_display.sv ----
// running-mode monitor selection, display scaling and light-alarm handling
// Behaviour
// - power-on shows item from initial selection
// - advance key steps through fourteen items
// - initial selection codes map to items
// - speed selection picks displayed speed quantity
// - unit indicators encode displayed unit
// - above 9999 show tenth, light x10
// - voltage shows u in lowest digit
// - PID items only with PID enabled
// - PID command/output blink lowest decimal point
// - PID feedback lights lowest decimal point
// - load factor shows percent letter lowest
// - motor output blinks kW indicator
// - analog item needs analog terminal 20
// - filter shown quantity by filter setting
// - heavy trips, light blinks local-run indicator
// - light alarm only when selected as such
// - terminals set to 98 drive alarm output
// - keep current and three previous causes
// - acknowledge returns display to running item
// - acknowledge clears indication only if cause gone
// - heavy alarm enters alarm mode with code
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "mda_defines.svh"
module mda_monitor_display #(
  parameter int VW          = 17,
  parameter int NTERM       = 6,
  parameter int NCAUSE      = 64,
  parameter int SAMPLE_CYC  = `MDA_SAMPLE_US * `MDA_CLK_MHZ,
  parameter int BLINK_TICKS = `MDA_BLINK_MS * `MDA_US_PER_MS / `MDA_SAMPLE_US
) (
  // clock and reset
  input  wire logic                     CLOCK_I,
  input  wire logic                     ARST_N_I,
  // wishbone slave
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [7:0]               WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire logic [31:0]              WB_DAT_I,
  output logic      [31:0]              WB_DAT_O,
  output logic                          WB_ACK_O,
  // keypad keys, asynchronous pins
  input  wire logic                     KEY_ADV_I,
  input  wire logic                     KEY_ACK_I,
  // drive state, same clock
  input  wire logic [NCAUSE-1:0]        ABNORMAL_I,
  input  wire logic                     KEYPAD_READY_I,
  input  wire logic [`MDA_N_QTY*VW-1:0] QTY_I,
  // display
  output logic      [13:0]              DISP_VALUE_O,
  output logic      [1:0]               DISP_CHAR_O,
  output logic                          DISP_DP_O,
  output logic                          DISP_X10_O,
  output logic                          LED_HZ_O,
  output logic                          LED_A_O,
  output logic                          LED_KW_O,
  output logic                          LOCAL_RUN_O,
  output logic                          LIGHT_ALARM_OUTPUT_SHOW_O,
  // alarm state
  output logic                          ALARM_MODE_O,
  output logic      [5:0]               ALARM_CODE_O,
  output logic      [NTERM-1:0]         LIGHT_ALARM_OUTPUT_TERM_O
);
  localparam int SCW = $clog2(SAMPLE_CYC + 1);
  localparam int BCW = $clog2(BLINK_TICKS + 1);
  localparam int AW  = VW + `MDA_FRAC;

  // elaboration checks
  initial begin
    if (VW < 14 || VW > 24) $error("VW out of range");
    if (NTERM < 1 || NTERM > 8) $error("NTERM out of range");
    if (NCAUSE < 2 || NCAUSE > 64) $error("NCAUSE out of range");
    if (SAMPLE_CYC < 2 || BLINK_TICKS < 1) $error("bad timing counts");
  end

  logic [31:0] cfg, anl, do0, do1, lsel1, lsel2;
  logic [7:0]  hist [4];
  mda_pkg::mda_mode_e mode;
  logic [3:0]  cur_idx, eff_idx, init_idx, next_idx;
  logic        manual, light_alarm_output_show, light_alarm_output_latched, blink, tick;
  logic        adv_s1, adv_s2, adv_s3, ack_s1, ack_s2, ack_s3;
  logic        adv_press, ack_press, pid_on, anl_on;
  logic [NCAUSE-1:0] lmask, light_act, heavy_act, prev_light, new_light;
  logic [SCW-1:0] sample_cnt;
  logic [BCW-1:0] blink_cnt;
  mda_pkg::mda_qty_e qidx, qprev;
  mda_pkg::mda_item_e eff_item;
  logic [VW-1:0] raw, filt, q10;
  logic [AW-1:0] acc;
  logic signed [AW:0] diff, step;
  logic [13:0] shown;
  logic        over, u_hz, u_a, u_kw, kw_blink, dp_on, dp_blink;
  mda_pkg::mda_char_e ch;
  logic        wr;
  logic [63:0] dosel;

  // item at each position of the monitor sequence
  function automatic mda_pkg::mda_item_e item_at(input logic [3:0] i);
    case (i)
      4'h0:    item_at = mda_pkg::IT_SPEED;
      4'h1:    item_at = mda_pkg::IT_CURR;
      4'h2:    item_at = mda_pkg::IT_VOLT;
      4'h3:    item_at = mda_pkg::IT_TORQ;
      4'h4:    item_at = mda_pkg::IT_PWR;
      4'h5:    item_at = mda_pkg::IT_PIDC;
      4'h6:    item_at = mda_pkg::IT_PIDF;
      4'h7:    item_at = mda_pkg::IT_PIDO;
      4'h8:    item_at = mda_pkg::IT_LOAD;
      4'h9:    item_at = mda_pkg::IT_MOUT;
      4'ha:    item_at = mda_pkg::IT_ANLG;
      4'hb:    item_at = mda_pkg::IT_TCUR;
      4'hc:    item_at = mda_pkg::IT_FLUX;
      4'hd:    item_at = mda_pkg::IT_ENER;
      default: item_at = mda_pkg::IT_SPEED;
    endcase
  endfunction

  // whether an item may be offered now
  function automatic logic avail(input logic [3:0] i, input logic pid,
                                 input logic an);
    mda_pkg::mda_item_e it;
    it = item_at(i);
    if (it == mda_pkg::IT_PIDC || it == mda_pkg::IT_PIDF ||
        it == mda_pkg::IT_PIDO) begin
      avail = pid;
    end else if (it == mda_pkg::IT_ANLG) begin
      avail = an;
    end else begin
      avail = 1'b1;
    end
  endfunction

  // lowest active cause number
  function automatic logic [5:0] low_set(input logic [NCAUSE-1:0] v);
    low_set = '0;
    for (int b = NCAUSE - 1; b >= 0; b--) begin
      if (v[b]) begin
        low_set = 6'(b);
      end
    end
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[b*8 +: 8] = n[b*8 +: 8];
      end
    end
  endfunction

  // key synchronisers and press detection
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      {adv_s1, adv_s2, adv_s3} <= 3'h0;
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
    end else begin
      {adv_s3, adv_s2, adv_s1} <= {adv_s2, adv_s1, KEY_ADV_I};
      {ack_s3, ack_s2, ack_s1} <= {ack_s2, ack_s1, KEY_ACK_I};
    end
  end
  assign adv_press = adv_s2 & ~adv_s3;
  assign ack_press = ack_s2 & ~ack_s3;

  // filter sample tick and blink phase divider
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sample_cnt <= '0;
      blink_cnt  <= '0;
      tick       <= 1'b0;
      blink      <= 1'b0;
    end else begin
      tick <= (sample_cnt == SCW'(SAMPLE_CYC - 1));
      if (sample_cnt == SCW'(SAMPLE_CYC - 1)) begin
        sample_cnt <= '0;
      end else begin
        sample_cnt <= sample_cnt + 1'b1;
      end
      if (tick) begin
        if (blink_cnt == BCW'(BLINK_TICKS - 1)) begin
          blink_cnt <= '0;
          blink     <= ~blink;
        end else begin
          blink_cnt <= blink_cnt + 1'b1;
        end
      end
    end
  end

  // wishbone register writes, landing at the edge that sees ack high
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cfg   <= `MDA_RST_CFG;
      anl   <= `MDA_RST_FN;
      do0   <= `MDA_RST_FN;
      do1   <= `MDA_RST_FN;
      lsel1 <= `MDA_RST_LSEL;
      lsel2 <= `MDA_RST_LSEL;
    end else if (wr) begin
      if (WB_ADR_I == `MDA_OFS_CFG) begin
        cfg <= merge(cfg, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == `MDA_OFS_ANL) begin
        anl <= merge(anl, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == `MDA_OFS_DO0) begin
        do0 <= merge(do0, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == `MDA_OFS_DO1) begin
        do1 <= merge(do1, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == `MDA_OFS_LSEL1) begin
        lsel1 <= merge(lsel1, WB_DAT_I, WB_SEL_I);
      end else if (WB_ADR_I == `MDA_OFS_LSEL2) begin
        lsel2 <= merge(lsel2, WB_DAT_I, WB_SEL_I);
      end
    end
  end

  // wishbone ack and read data, one wait state
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
      WB_DAT_O <= '0;
      if (WB_CYC_I & WB_STB_I & ~WB_WE_I & ~WB_ACK_O) begin
        if (WB_ADR_I == `MDA_OFS_CFG) begin
          WB_DAT_O <= cfg;
        end else if (WB_ADR_I == `MDA_OFS_ANL) begin
          WB_DAT_O <= anl;
        end else if (WB_ADR_I == `MDA_OFS_DO0) begin
          WB_DAT_O <= do0;
        end else if (WB_ADR_I == `MDA_OFS_DO1) begin
          WB_DAT_O <= do1;
        end else if (WB_ADR_I == `MDA_OFS_LSEL1) begin
          WB_DAT_O <= lsel1;
        end else if (WB_ADR_I == `MDA_OFS_LSEL2) begin
          WB_DAT_O <= lsel2;
        end else if (WB_ADR_I == `MDA_OFS_STAT) begin
          WB_DAT_O[`MDA_ST_MODE]  <= (mode == mda_pkg::MDA_ALARM);
          WB_DAT_O[`MDA_ST_LATCH] <= light_alarm_output_latched;
          WB_DAT_O[`MDA_ST_SHOW]  <= light_alarm_output_show;
          WB_DAT_O[`MDA_ST_IDX]   <= eff_idx;
          WB_DAT_O[`MDA_ST_ITEM]  <= eff_item;
          WB_DAT_O[`MDA_ST_CODE]  <= ALARM_CODE_O;
        end else if (WB_ADR_I == `MDA_OFS_HIST) begin
          WB_DAT_O <= {hist[3], hist[2], hist[1], hist[0]};
        end
      end
    end
  end

  // feature enables from the settings
  always_comb begin
    pid_on = (cfg[`MDA_CFG_PID] != '0);
    anl_on = 1'b0;
    for (int a = 0; a < `MDA_N_ANL; a++) begin
      if (anl[a*`MDA_FLD_STEP +: `MDA_ANL_W] == `MDA_FN_ANLMON) begin
        anl_on = 1'b1;
      end
    end
  end

  // initial item lookup and next available item
  always_comb begin
    init_idx = '0;
    for (int i = 0; i < `MDA_N_ITEMS; i++) begin
      if (item_at(4'(i)) == mda_pkg::mda_item_e'(cfg[`MDA_CFG_INIT]) &&
          avail(4'(i), pid_on, anl_on)) begin
        init_idx = 4'(i);
      end
    end
    if (!manual) begin
      eff_idx = init_idx;
    end else if (avail(cur_idx, pid_on, anl_on)) begin
      eff_idx = cur_idx;
    end else begin
      eff_idx = '0;
    end
    eff_item = item_at(eff_idx);
    next_idx = eff_idx;
    for (int o = `MDA_N_ITEMS; o >= 1; o--) begin
      if (avail(4'((int'(eff_idx) + o) % `MDA_N_ITEMS), pid_on, anl_on)) begin
        next_idx = 4'((int'(eff_idx) + o) % `MDA_N_ITEMS);
      end
    end
  end

  // monitor item stepping
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cur_idx <= '0;
      manual  <= 1'b0;
    end else if (adv_press && mode == mda_pkg::MDA_RUN && !light_alarm_output_show) begin
      cur_idx <= next_idx;
      manual  <= 1'b1;
    end
  end

  // light and heavy alarm classification
  assign lmask     = NCAUSE'({lsel2, lsel1});
  assign light_act = ABNORMAL_I & lmask;
  assign heavy_act = ABNORMAL_I & ~lmask;
  assign new_light = light_act & ~prev_light;

  // alarm mode, light-alarm indication and cause history
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode         <= mda_pkg::MDA_RUN;
      ALARM_CODE_O <= '0;
      prev_light   <= '0;
      light_alarm_output_show    <= 1'b0;
      light_alarm_output_latched <= 1'b0;
      for (int h = 0; h < 4; h++) begin
        hist[h] <= '0;
      end
    end else begin
      prev_light <= light_act;
      if (heavy_act != '0) begin
        mode         <= mda_pkg::MDA_ALARM;
        ALARM_CODE_O <= low_set(heavy_act);
      end else if (mode == mda_pkg::MDA_ALARM && ack_press) begin
        mode <= mda_pkg::MDA_RUN;
      end
      if (new_light != '0) begin
        light_alarm_output_show    <= 1'b1;
        light_alarm_output_latched <= 1'b1;
        hist[0] <= 8'(low_set(new_light)) | (8'h1 << `MDA_HIST_VLD);
        for (int h = 1; h < 4; h++) begin
          hist[h] <= hist[h-1];
        end
      end else if (ack_press && mode == mda_pkg::MDA_RUN) begin
        light_alarm_output_show <= 1'b0;
        if (light_act == '0) begin
          light_alarm_output_latched <= 1'b0;
        end
      end
    end
  end

  // quantity shown for the current item
  always_comb begin
    qidx = mda_pkg::Q_F1;
    case (eff_item)
      mda_pkg::IT_SPEED: begin
        case (mda_pkg::mda_spd_e'(cfg[`MDA_CFG_SPD]))
          mda_pkg::SP_F2:    qidx = mda_pkg::Q_F2;
          mda_pkg::SP_REF:   qidx = mda_pkg::Q_REF;
          mda_pkg::SP_MOT:   qidx = mda_pkg::Q_MOT;
          mda_pkg::SP_SHAFT: qidx = mda_pkg::Q_SHAFT;
          mda_pkg::SP_LINE:  qidx = mda_pkg::Q_LINE;
          mda_pkg::SP_PCT:   qidx = mda_pkg::Q_SPCT;
          default:           qidx = mda_pkg::Q_F1;
        endcase
      end
      mda_pkg::IT_CURR: qidx = mda_pkg::Q_CURR;
      mda_pkg::IT_VOLT: qidx = mda_pkg::Q_VOLT;
      mda_pkg::IT_TORQ: qidx = mda_pkg::Q_TORQ;
      mda_pkg::IT_PWR:  qidx = mda_pkg::Q_PWR;
      mda_pkg::IT_PIDC: qidx = mda_pkg::Q_PIDC;
      mda_pkg::IT_PIDF: qidx = mda_pkg::Q_PIDF;
      mda_pkg::IT_PIDO: qidx = mda_pkg::Q_PIDO;
      mda_pkg::IT_LOAD: qidx = mda_pkg::Q_LOAD;
      mda_pkg::IT_MOUT: qidx = mda_pkg::Q_MOUT;
      mda_pkg::IT_ANLG: qidx = mda_pkg::Q_ANLG;
      mda_pkg::IT_TCUR: qidx = mda_pkg::Q_TCUR;
      mda_pkg::IT_FLUX: qidx = mda_pkg::Q_FLUX;
      mda_pkg::IT_ENER: qidx = mda_pkg::Q_ENER;
      default:          qidx = mda_pkg::Q_F1;
    endcase
  end

  // units, lowest-digit letter and decimal point per quantity
  always_comb begin
    {u_hz, u_a, u_kw, kw_blink, dp_on, dp_blink} = 6'h00;
    ch = mda_pkg::CH_NONE;
    case (qidx)
      mda_pkg::Q_F1, mda_pkg::Q_F2, mda_pkg::Q_REF: u_hz = 1'b1;
      mda_pkg::Q_MOT, mda_pkg::Q_SHAFT: {u_hz, u_a} = 2'h3;
      mda_pkg::Q_LINE: {u_a, u_kw} = 2'h3;
      mda_pkg::Q_CURR: u_a = 1'b1;
      mda_pkg::Q_PWR:  u_kw = 1'b1;
      mda_pkg::Q_MOUT: {u_kw, kw_blink} = 2'h3;
      mda_pkg::Q_VOLT: ch = mda_pkg::CH_VOLT;
      mda_pkg::Q_LOAD: ch = mda_pkg::CH_PCT;
      mda_pkg::Q_PIDC, mda_pkg::Q_PIDO: {dp_on, dp_blink} = 2'h3;
      mda_pkg::Q_PIDF: dp_on = 1'b1;
      default: ;
    endcase
  end

  // display filter: first-order low pass, reloaded on item change
  assign raw  = QTY_I[int'(qidx)*VW +: VW];
  assign diff = $signed({1'b0, raw, `MDA_FRAC'(0)}) - $signed({1'b0, acc});
  assign step = diff >>> cfg[`MDA_CFG_FILT];
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      acc   <= '0;
      qprev <= mda_pkg::Q_F1;
    end else begin
      qprev <= qidx;
      if (qidx != qprev) begin
        acc <= {raw, `MDA_FRAC'(0)};
      end else if (tick) begin
        acc <= acc + step[AW-1:0];
      end
    end
  end
  assign filt = acc[AW-1:`MDA_FRAC];

  // scaling for the four-digit display
  assign over  = filt > VW'(`MDA_DISP_MAX);
  assign q10   = filt / VW'(`MDA_DIV);
  assign shown = !over ? filt[13:0] :
                 (q10 > VW'(`MDA_DISP_MAX)) ? `MDA_DISP_MAX : q10[13:0];

  // registered display outputs
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DISP_VALUE_O <= '0;
      DISP_CHAR_O  <= mda_pkg::CH_NONE;
      {DISP_DP_O, DISP_X10_O, LED_HZ_O, LED_A_O, LED_KW_O} <= 5'h00;
      {LOCAL_RUN_O, LIGHT_ALARM_OUTPUT_SHOW_O, ALARM_MODE_O} <= 3'h0;
    end else begin
      ALARM_MODE_O <= (mode == mda_pkg::MDA_ALARM);
      LIGHT_ALARM_OUTPUT_SHOW_O  <= light_alarm_output_show && mode == mda_pkg::MDA_RUN;
      LOCAL_RUN_O  <= light_alarm_output_latched ? blink : KEYPAD_READY_I;
      if (mode == mda_pkg::MDA_ALARM || light_alarm_output_show) begin
        DISP_VALUE_O <= '0;
        DISP_CHAR_O  <= mda_pkg::CH_NONE;
        {DISP_DP_O, DISP_X10_O, LED_HZ_O, LED_A_O, LED_KW_O} <= 5'h00;
      end else begin
        DISP_VALUE_O <= shown;
        DISP_X10_O   <= over;
        DISP_CHAR_O  <= ch;
        DISP_DP_O    <= dp_on & (~dp_blink | blink);
        LED_HZ_O     <= u_hz;
        LED_A_O      <= u_a;
        LED_KW_O     <= u_kw & (~kw_blink | blink);
      end
    end
  end

  // terminal function fields of both output registers
  assign dosel = {do1, do0};

  // light-alarm output per digital output terminal
  for (genvar t = 0; t < NTERM; t++) begin : g_term
    always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        LIGHT_ALARM_OUTPUT_TERM_O[t] <= 1'b0;
      end else begin
        LIGHT_ALARM_OUTPUT_TERM_O[t] <= light_alarm_output_latched &&
          (dosel[t*`MDA_FLD_STEP +: `MDA_DO_W] == `MDA_FN_LIGHT_ALARM_OUTPUT);
      end
    end
  end
endmodule

// ---- mda_keypad_model.sv ----
// keypad model: presses the advance and acknowledge keys
`timescale 1ns/1ps
module mda_keypad_model (
  // clock
  input  wire logic clk_i,
  // key pins, active high
  output logic      key_adv_o,
  output logic      key_ack_o
);
  // keys rest released
  initial begin
    key_adv_o = 1'b0;
    key_ack_o = 1'b0;
  end
  // one press held long enough for the two-stage sync to see one edge
  task automatic press(input logic adv);
    if (adv) begin
      key_adv_o <= 1'b1;
    end else begin
      key_ack_o <= 1'b1;
    end
    repeat (6) @(posedge clk_i);
    key_adv_o <= 1'b0;
    key_ack_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ---- mda_monitor_display_props.sv ----
// checker: bus handshake, display limits, unit codes, alarm blanking
`timescale 1ns/1ps
module mda_monitor_display_props (
  // clock and reset
  input wire logic        CLOCK_I,
  input wire logic        ARST_N_I,
  // bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  // display and alarm state
  input wire logic [13:0] DISP_VALUE_O,
  input wire logic [1:0]  DISP_CHAR_O,
  input wire logic        DISP_DP_O,
  input wire logic        DISP_X10_O,
  input wire logic        LED_HZ_O,
  input wire logic        LED_A_O,
  input wire logic        LED_KW_O,
  input wire logic        LIGHT_ALARM_OUTPUT_SHOW_O,
  input wire logic        ALARM_MODE_O
);
  // single domain, reset disables all checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);
  a_ack_answer: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked next cycle");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_STB_I))
    else $error("ack without request");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  a_value_limit: assert property (DISP_VALUE_O <= 14'h270f)
    else $error("display value above four digits");
  a_x10_range: assert property (
    DISP_X10_O |-> DISP_VALUE_O >= 14'h3e8)
    else $error("x10 lit with small value");
  a_unit_code: assert property (!(LED_HZ_O && LED_KW_O))
    else $error("hz and kw lit together");
  a_char_units: assert property (
    DISP_CHAR_O != 2'h0 |-> !LED_HZ_O && !LED_A_O)
    else $error("letter item with unit led");
  a_light_blank: assert property (
    LIGHT_ALARM_OUTPUT_SHOW_O |-> DISP_VALUE_O == 14'h0 && !DISP_DP_O && !DISP_X10_O)
    else $error("monitor shown under light alarm text");
  a_alarm_blank: assert property (
    ALARM_MODE_O |-> DISP_VALUE_O == 14'h0 && !LED_HZ_O)
    else $error("monitor shown in alarm mode");
endmodule
bind mda_monitor_display mda_monitor_display_props u_props (
  .CLOCK_I(CLOCK_I), .ARST_N_I(ARST_N_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
  .DISP_VALUE_O(DISP_VALUE_O), .DISP_CHAR_O(DISP_CHAR_O),
  .DISP_DP_O(DISP_DP_O), .DISP_X10_O(DISP_X10_O), .LED_HZ_O(LED_HZ_O),
  .LED_A_O(LED_A_O), .LED_KW_O(LED_KW_O), .LIGHT_ALARM_OUTPUT_SHOW_O(LIGHT_ALARM_OUTPUT_SHOW_O),
  .ALARM_MODE_O(ALARM_MODE_O));

// ---- mda_monitor_display_tb_top.sv ----
// bench: item table model, key stepping, light and heavy alarms
`timescale 1ns/1ps
module mda_monitor_display_tb_top;
  localparam int VW = 17;
  logic             clk, arst_n, cyc, stb, we, kadv, kack, krdy;
  logic [7:0]       adr;
  logic [3:0]       sel;
  logic [31:0]      dat, rd, rd_w, x;
  logic [63:0]      abn;
  logic [20*VW-1:0] qty;
  logic [13:0]      val;
  logic [1:0]       chr;
  logic [5:0]       acode, term;
  logic             dp, x10, hz, la, kw, lrun, show, amode, ack;
  int               fails, samples_checked, v, q;
  int codes[14] = '{0, 3, 4, 8, 9, 10, 12, 14, 15, 16, 17, 23, 24, 25};
  int leds[14]  = '{4, 2, 0, 0, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0};
  int sleds[8]  = '{4, 4, 4, 6, 6, 3, 0, 0};
  // clock, 5 ns period
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  mda_monitor_display #(.SAMPLE_CYC(10), .BLINK_TICKS(2)) uut (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(rd_w), .WB_ACK_O(ack), .KEY_ADV_I(kadv), .KEY_ACK_I(kack),
    .ABNORMAL_I(abn), .KEYPAD_READY_I(krdy), .QTY_I(qty),
    .DISP_VALUE_O(val), .DISP_CHAR_O(chr), .DISP_DP_O(dp),
    .DISP_X10_O(x10), .LED_HZ_O(hz), .LED_A_O(la), .LED_KW_O(kw),
    .LOCAL_RUN_O(lrun), .LIGHT_ALARM_OUTPUT_SHOW_O(show), .ALARM_MODE_O(amode),
    .ALARM_CODE_O(acode), .LIGHT_ALARM_OUTPUT_TERM_O(term));
  mda_keypad_model kp (.clk_i(clk), .key_adv_o(kadv), .key_ack_o(kack));
  // count a comparison, report a mismatch at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // classic single cycle; request held until the edge that sees ack high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rd_w;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  // drive one quantity and compare the display word with the model
  task automatic disp_chk(input int qi, input logic [31:0] ex,
                          input logic [31:0] mk);
    x = lfsr(x);
    v = (qi % 2) ? x % 10000 : 10000 + x % 10000;
    qty[qi*VW +: VW] <= v[16:0];
    repeat (14) @(posedge clk); // filter updates once per sample tick
    ex = ex | (32'(v > 9999) << 17) | ((v > 9999) ? v / 10 : v);
    check({11'h0, chr, dp, x10, hz, la, kw, val} & mk, ex & mk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog: the tests need under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
  // main sequence
  initial begin
    {arst_n, cyc, stb, we, adr, dat, abn, qty} = '0;
    sel = 4'hf;
    krdy = 1'b1;
    x = 32'h724f;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h0103_0702);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0103_0702);
    sel <= 4'h2;
    wb(1'b1, 8'h00, 32'hffff_ffff);
    sel <= 4'hf;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0103_ff02);
    $display("test bus done");
    wb(1'b1, 8'h04, 32'h14);
    for (int i = 0; i < 14; i++) begin
      wb(1'b1, 8'h00, 32'h0100_0000 | codes[i]);
      disp_chk((i == 0) ? 0 : i + 6, (leds[i] << 14) | ((i == 2) << 19) |
        ((i == 8) << 20) | ((i == 6) << 18),
        32'h1f_ffff & ~((i == 9) << 14) & ~((i == 5 || i == 7) << 18));
    end
    for (int s = 0; s < 8; s++) begin
      if (s == 6) continue;
      wb(1'b1, 8'h00, 32'h0100_0000 | (s << 8));
      disp_chk((s == 7) ? 6 : s, sleds[s] << 14, 32'h1f_ffff);
    end
    $display("test items done");
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h00, 32'h0);
    for (int i = 1; i <= 14; i++) begin
      if (i == 5 || i == 6 || i == 7 || i == 10) continue;
      kp.press(1'b1);
      wb(1'b0, 8'h18, 32'h0);
      check(32'(rd[20:16]), codes[i % 14]);
    end
    $display("test advance done");
    wb(1'b1, 8'h10, 32'h4);
    wb(1'b1, 8'h08, 32'h62);
    abn[2] <= 1'b1;
    repeat (4) @(posedge clk);
    check({amode, show, term[0]}, 3'b011);
    q = 0;
    v = lrun;
    repeat (60) begin
      @(posedge clk);
      if (lrun !== v[0]) q++;
      v = lrun;
    end
    check(q > 0, 1'b1);
    wb(1'b0, 8'h1c, 32'h0);
    check(rd[7:0], 8'h82);
    kp.press(1'b0);
    check({show, term[0]}, 2'b01);
    abn[2] <= 1'b0;
    kp.press(1'b0);
    check({show, term[0], lrun}, 3'b001);
    krdy <= 1'b0;
    repeat (3) @(posedge clk);
    check(lrun, 1'b0);
    krdy <= 1'b1;
    $display("test light alarm done");
    abn[5] <= 1'b1;
    repeat (4) @(posedge clk);
    check({amode, acode}, {1'b1, 6'h05});
    abn[5] <= 1'b0;
    kp.press(1'b0);
    check(amode, 1'b0);
    $display("test heavy alarm done");
    print_verdict();
  end
endmodule
